// ==== hdl/msb_bank.sv ====
// Purpose: Single-bit discrete input and coil map seen by a remote master.
// Assumes: Framing is decoded elsewhere; one access per request cycle.
// Notes:   Starts are pulses; sequence, purge and standby coil reads show live activity feedback.

module msb_bank import msb_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Master access port
  input  wire logic              req_valid,
  input  wire msb_req_t          req,
  output logic                   rsp_valid,
  output logic                   rsp_data,
  // Status pins and option strap
  input  wire msb_status_t       status_pins,
  input  wire logic              regulator_opt_fitted,
  // Activity feedback
  input  wire logic [SEQ_N-1:0]  seq_running,
  input  wire logic              purge_active,
  input  wire logic              standby_active,
  // Activity starts
  output logic                   seq_start,
  output logic [6:0]             seq_start_num,
  output logic                   purge_start,
  output logic                   standby_start,
  // Control outputs
  output logic [CTRL_N-1:0]      ctrl_out
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [CTRL_N-1:0] ctrl;
    logic              rsp_valid;
    logic              rsp_data;
    logic              seq_go;
    logic [6:0]        seq_num;
    logic              purge_go;
    logic              standby_go;
    logic              opt_fitted;
    logic              opt_taken;
  } msb_bank_state_t;

  msb_bank_state_t st;
  msb_bank_state_t next_st;
  msb_status_t     stat;
  logic [STAT_N-1:0] stat_bits;

  // ************************************************************
  // Decoders
  // ************************************************************

  // Coil map region of a point address
  function automatic msb_region_t coil_region(input logic [ADDR_W-1:0] a);
    msb_region_t r;
    r = MSB_RG_NONE;
    if (a <= COIL_SEQ_LAST) begin
      r = MSB_RG_SEQ;
    end else if (a == COIL_PURGE) begin
      r = MSB_RG_PURGE;
    end else if (a == COIL_STANDBY) begin
      r = MSB_RG_STANDBY;
    end else if (a >= COIL_CTRL_FIRST && a <= COIL_CTRL_LAST) begin
      r = MSB_RG_CTRL;
    end
    return r;
  endfunction

  // Control output index of a coil in the control range
  function automatic logic [3:0] ctrl_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - COIL_CTRL_FIRST;
    return d[3:0];
  endfunction

  // ************************************************************
  // Status synchroniser
  // ************************************************************
  msb_sync u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (status_pins),
    .dout (stat_bits)
  );

  assign stat = msb_status_t'(stat_bits);

  // ************************************************************
  // Next state
  // ************************************************************

  // Every request answers next cycle; writes answer with 0
  always_comb begin
    msb_region_t rg;
    logic        di;
    rg                 = MSB_RG_NONE;
    di                 = 1'b0;
    next_st            = st;
    next_st.seq_go     = 1'b0;
    next_st.purge_go   = 1'b0;
    next_st.standby_go = 1'b0;
    next_st.rsp_valid  = req_valid;
    next_st.rsp_data   = 1'b0;
    // Strap is caught once after reset release, never during it
    if (!st.opt_taken) begin
      next_st.opt_taken  = 1'b1;
      next_st.opt_fitted = regulator_opt_fitted;
    end
    // Discrete input points; 0-7 belong to other logic and read 0
    case (req.addr)
      DI_RELAY_LINK:   di = stat.relay_fail;
      DI_PANEL_LINK:   di = stat.panel_fail;
      DI_LAMP_LINK:    di = stat.lamp_gen_fail | stat.lamp_photo_fail;
      DI_ANALOG_CAL:   di = stat.analog_cal_warn;
      DI_HEALTHY:      di = stat.healthy;
      DI_GEN_UNSTABLE: di = stat.gen_unstable;
      DI_CAL_ACTIVE:   di = stat.cal_active;
      DI_SEQ_ACTIVE:   di = |seq_running;
      DI_REG_PRESSURE: di = st.opt_fitted & stat.reg_press_warn;
      default:         di = 1'b0;
    endcase
    if (req_valid && req.is_coil) begin
      rg = coil_region(req.addr);
      if (req.write) begin
        // Only a 1 starts activity; a 0 stops nothing
        case (rg)
          MSB_RG_SEQ: begin
            if (req.wdata) begin
              next_st.seq_go  = 1'b1;
              next_st.seq_num = req.addr[6:0];
            end
          end
          MSB_RG_PURGE: begin
            next_st.purge_go = req.wdata;
          end
          MSB_RG_STANDBY: begin
            next_st.standby_go = req.wdata;
          end
          MSB_RG_CTRL: begin
            next_st.ctrl[ctrl_index(req.addr)] = req.wdata;
          end
          default: begin
            next_st.ctrl = st.ctrl;
          end
        endcase
      end else begin
        // Activity coils read live activity, each bit on its own; control coils read back st.ctrl
        case (rg)
          MSB_RG_SEQ:     next_st.rsp_data = seq_running[req.addr[6:0]];
          MSB_RG_PURGE:   next_st.rsp_data = purge_active;
          MSB_RG_STANDBY: next_st.rsp_data = standby_active;
          MSB_RG_CTRL:    next_st.rsp_data = st.ctrl[ctrl_index(req.addr)];
          default:        next_st.rsp_data = 1'b0;
        endcase
      end
    end else if (req_valid && !req.write) begin
      next_st.rsp_data = di;
    end
    // Discrete writes change nothing and answer with 0
    if (req_valid && !req.is_coil && req.write) begin
      next_st.rsp_data = 1'b0;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{ctrl: CTRL_RESET, seq_num: 7'h00, default: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flip-flops
  assign rsp_valid     = st.rsp_valid;
  assign rsp_data      = st.rsp_data;
  assign seq_start     = st.seq_go;
  assign seq_start_num = st.seq_num;
  assign purge_start   = st.purge_go;
  assign standby_start = st.standby_go;
  assign ctrl_out      = st.ctrl;

  // ************************************************************
  // Checks
  // ************************************************************

  // Shorthand for request classes seen at an edge
  logic rd_di;
  logic wr_coil;
  logic rd_coil;
  assign rd_di   = req_valid && !req.is_coil && !req.write;
  assign wr_coil = req_valid && req.is_coil && req.write;
  assign rd_coil = req_valid && req.is_coil && !req.write;

  a_relay_panel_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_di && (req.addr == DI_RELAY_LINK || req.addr == DI_PANEL_LINK)
    |=> rsp_valid && rsp_data == ($past(req.addr) == DI_RELAY_LINK ?
        $past(stat.relay_fail) : $past(stat.panel_fail)))
    else $error("relay or panel warning read wrong");

  a_lamp_link_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_di && req.addr == DI_LAMP_LINK
    |=> rsp_data == ($past(stat.lamp_gen_fail) || $past(stat.lamp_photo_fail)))
    else $error("lamp driver warning read wrong");

  a_cal_warn_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_di && req.addr == DI_ANALOG_CAL |=> rsp_data == $past(stat.analog_cal_warn))
    else $error("analog calibration warning read wrong");

  a_healthy_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_di && req.addr == DI_HEALTHY |=> rsp_valid && rsp_data == $past(stat.healthy))
    else $error("healthy point differs from healthy signal");

  a_gen_unstable_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_di && req.addr == DI_GEN_UNSTABLE |=> rsp_data == $past(stat.gen_unstable))
    else $error("generator unstable read wrong");

  a_pressure_option_gate: assert property (
    @(posedge clk) disable iff (rst)
    rd_di && req.addr == DI_REG_PRESSURE && !st.opt_fitted |=> !rsp_data)
    else $error("pressure warning shown without option");

  a_seq_write_start: assert property (
    @(posedge clk) disable iff (rst)
    wr_coil && req.wdata && req.addr <= COIL_SEQ_LAST
    |=> seq_start && seq_start_num == $past(req.addr[6:0])
    ##1 (seq_start == $past(wr_coil && req.wdata && req.addr <= COIL_SEQ_LAST)))
    else $error("sequence start pulse wrong");

  a_seq_zero_ignored: assert property (
    @(posedge clk) disable iff (rst)
    wr_coil && !req.wdata && req.addr <= COIL_SEQ_LAST
    |=> !seq_start && !purge_start && !standby_start && $stable(ctrl_out))
    else $error("write of 0 to sequence coil had effect");

  a_seq_readback: assert property (
    @(posedge clk) disable iff (rst)
    rd_coil && req.addr <= COIL_SEQ_LAST
    |=> rsp_valid && rsp_data == $past(seq_running[req.addr[6:0]]))
    else $error("sequence coil read does not match activity");

  a_seq_nested_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_coil && req.addr <= COIL_SEQ_LAST && seq_running[req.addr[6:0]]
    && $countones(seq_running) > 1 |=> rsp_data)
    else $error("nested sequence hidden on read");

  a_purge_start: assert property (
    @(posedge clk) disable iff (rst)
    wr_coil && req.addr == COIL_PURGE |=> purge_start == $past(req.wdata))
    else $error("purge start wrong");

  a_purge_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_coil && req.addr == COIL_PURGE |=> rsp_data == $past(purge_active))
    else $error("purge coil read wrong");

  a_standby_start: assert property (
    @(posedge clk) disable iff (rst)
    wr_coil && req.addr == COIL_STANDBY
    |=> standby_start == $past(req.wdata) && !purge_start && !seq_start)
    else $error("standby start wrong");

  a_standby_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_coil && req.addr == COIL_STANDBY |=> rsp_data == $past(standby_active))
    else $error("standby coil read wrong");

  a_ctrl_write_read: assert property (
    @(posedge clk) disable iff (rst)
    wr_coil && req.addr >= COIL_CTRL_FIRST && req.addr <= COIL_CTRL_LAST
    ##1 (rd_coil && req.addr == $past(req.addr))
    |=> rsp_data == $past(req.wdata, 2))
    else $error("control output did not read back written value");

  a_di_write_ignored: assert property (
    @(posedge clk) disable iff (rst)
    req_valid && !req.is_coil && req.write
    |=> $stable(ctrl_out) && !seq_start && !purge_start && !standby_start && !rsp_data)
    else $error("discrete input write had effect");

  a_unmapped_coil: assert property (
    @(posedge clk) disable iff (rst)
    req_valid && req.is_coil
    && ((req.addr > COIL_STANDBY && req.addr < COIL_CTRL_FIRST) || req.addr > COIL_CTRL_LAST)
    |=> !rsp_data && $stable(ctrl_out) && !seq_start && !purge_start && !standby_start)
    else $error("unmapped coil access had effect");

  // Every taken request is answered on the very next edge, never later
  a_answer_next_cycle: assert property (
    @(posedge clk) disable iff (rst)
    rsp_valid == $past(req_valid))
    else $error("answer not one cycle after request");

  a_pressure_option_shown: assert property (
    @(posedge clk) disable iff (rst)
    rd_di && req.addr == DI_REG_PRESSURE && st.opt_fitted
    |=> rsp_data == $past(stat.reg_press_warn))
    else $error("pressure warning hidden with option fitted");

  a_ctrl_write_lands: assert property (
    @(posedge clk) disable iff (rst)
    wr_coil && req.addr >= COIL_CTRL_FIRST && req.addr <= COIL_CTRL_LAST
    |=> ctrl_out[$past(ctrl_index(req.addr))] == $past(req.wdata))
    else $error("control output write did not land");

  a_ctrl_others_kept: assert property (
    @(posedge clk) disable iff (rst)
    !wr_coil |=> $stable(ctrl_out))
    else $error("control outputs moved without a coil write");

  a_seq_active_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_di && req.addr == DI_SEQ_ACTIVE |=> rsp_data == $past(|seq_running))
    else $error("sequence active point read wrong");

  a_cal_active_read: assert property (
    @(posedge clk) disable iff (rst)
    rd_di && req.addr == DI_CAL_ACTIVE |=> rsp_data == $past(stat.cal_active))
    else $error("calibration active point read wrong");

  a_write_answers_zero: assert property (
    @(posedge clk) disable iff (rst)
    req_valid && req.write |=> rsp_valid && !rsp_data)
    else $error("write answered with data");

  // Points below the relay warning belong to other logic and read 0 here
  a_low_points_zero: assert property (
    @(posedge clk) disable iff (rst)
    rd_di && req.addr < DI_RELAY_LINK |=> !rsp_data)
    else $error("low discrete point read nonzero");

endmodule

// ==== hdl/msb_pkg.sv ====
// Purpose: Shared constants and types for the status and coil bank.
// Assumes: One system clock, asynchronous active-high reset.
// Notes:   Addresses are 0-based decimal point numbers of each table.

package msb_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int SEQ_N  = 100;
  localparam int CTRL_N = 12;
  localparam int STAT_N = 9;

  // ************************************************************
  // Discrete input addresses
  // ************************************************************
  localparam logic [7:0] DI_RELAY_LINK   = 8'h08;
  localparam logic [7:0] DI_LAMP_LINK    = 8'h09;
  localparam logic [7:0] DI_PANEL_LINK   = 8'h0a;
  localparam logic [7:0] DI_ANALOG_CAL   = 8'h0b;
  localparam logic [7:0] DI_HEALTHY      = 8'h0c;
  localparam logic [7:0] DI_GEN_UNSTABLE = 8'h0d;
  localparam logic [7:0] DI_CAL_ACTIVE   = 8'h0e;
  localparam logic [7:0] DI_SEQ_ACTIVE   = 8'h0f;
  localparam logic [7:0] DI_REG_PRESSURE = 8'h10;

  // ************************************************************
  // Coil addresses
  // ************************************************************
  localparam logic [7:0] COIL_SEQ_LAST   = 8'h63;
  localparam logic [7:0] COIL_PURGE      = 8'h64;
  localparam logic [7:0] COIL_STANDBY    = 8'h65;
  localparam logic [7:0] COIL_CTRL_FIRST = 8'hc8;
  localparam logic [7:0] COIL_CTRL_LAST  = 8'hd3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [11:0] CTRL_RESET     = 12'h000;
  localparam logic [8:0]  SYNC_RESET     = 9'h000;

  // Coil map regions
  typedef enum logic [2:0] {
    MSB_RG_NONE    = 3'h0,
    MSB_RG_SEQ     = 3'h1,
    MSB_RG_PURGE   = 3'h3,
    MSB_RG_STANDBY = 3'h2,
    MSB_RG_CTRL    = 3'h6
  } msb_region_t;

  // One access from the master: table, direction, point, value
  typedef struct packed {
    logic              is_coil;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic              wdata;
  } msb_req_t;

  // Status levels from the instrument, asynchronous to clk
  typedef struct packed {
    logic relay_fail;
    logic lamp_gen_fail;
    logic lamp_photo_fail;
    logic panel_fail;
    logic analog_cal_warn;
    logic healthy;
    logic gen_unstable;
    logic cal_active;
    logic reg_press_warn;
  } msb_status_t;

endpackage

// ==== hdl/msb_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for status pins.
// Assumes: Inputs are slow levels from outside the clk domain.
// Notes:   Output changes only once stages two and three agree.

module msb_sync import msb_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Levels
  input  wire logic [STAT_N-1:0] din,
  output logic      [STAT_N-1:0] dout
);

  typedef struct packed {
    logic [STAT_N-1:0] s1;
    logic [STAT_N-1:0] s2;
    logic [STAT_N-1:0] s3;
    logic [STAT_N-1:0] filt;
  } msb_sync_state_t;

  msb_sync_state_t st;
  msb_sync_state_t next_st;
  logic [STAT_N-1:0] next_filt;

  // Per-bit filter; stage one is only read by stage two
  genvar g;
  generate
    for (g = 0; g < STAT_N; g++) begin : g_bit
      assign next_filt[g] = (st.s2[g] == st.s3[g]) ? st.s3[g] : st.filt[g];
    end
  endgenerate

  // Next state
  always_comb begin
    next_st      = st;
    next_st.s1   = din;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.filt = next_filt;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= {SYNC_RESET, SYNC_RESET, SYNC_RESET, SYNC_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.filt;

endmodule

// ==== test/msb_activity_model.sv ====
// Purpose: Instrument core seen behind the bank: sequences, purge, standby.
// Assumes: Start pulses come from the bank on the same clock.
// Notes:   Activity runs until the bench raises stop_all.

module msb_activity_model import msb_pkg::*; (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Starts from the bank
  input  wire logic             seq_start,
  input  wire logic [6:0]       seq_start_num,
  input  wire logic             purge_start,
  input  wire logic             standby_start,
  // Bench control
  input  wire logic             stop_all,
  // Activity levels
  output logic      [SEQ_N-1:0] seq_running,
  output logic                  purge_active,
  output logic                  standby_active
);
  timeunit 1ns;
  timeprecision 100ps;

  // Activity answers one edge after the start pulse, like a slow core
  always_ff @(posedge clk or posedge rst) begin
    if (rst || stop_all) begin
      seq_running    <= '0;
      purge_active   <= 1'b0;
      standby_active <= 1'b0;
    end else begin
      if (seq_start) begin
        seq_running[seq_start_num] <= 1'b1;
      end
      if (purge_start) begin
        purge_active <= 1'b1;
      end
      if (standby_start) begin
        standby_active <= 1'b1;
      end
    end
  end
endmodule

// ==== test/msb_bank_tb.sv ====
// Purpose: Self-checking bench for the status and coil bank.
// Assumes: Requests driven at the falling edge, one per cycle.
// Notes:   Expected read data queued by the driver, checked by a monitor.

module msb_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import msb_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  logic              clk, rst, req_valid, strap, stop_all;
  msb_req_t          req;
  msb_status_t       pins;
  logic              rsp_valid, rsp_data, seq_start, purge_start, standby_start;
  logic              purge_active, standby_active, exp_purge, exp_stby;
  logic [6:0]        seq_start_num;
  logic [CTRL_N-1:0] ctrl_out, exp_ctrl;
  logic [SEQ_N-1:0]  seq_running, exp_seq;
  logic              rsp_q[$];
  logic [6:0]        start_q[$];
  int                errors, comparisons;

  msb_bank dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .status_pins(pins),
    .regulator_opt_fitted(strap), .seq_running(seq_running),
    .purge_active(purge_active), .standby_active(standby_active),
    .seq_start(seq_start), .seq_start_num(seq_start_num), .purge_start(purge_start),
    .standby_start(standby_start), .ctrl_out(ctrl_out));

  msb_activity_model core (.clk(clk), .rst(rst), .seq_start(seq_start),
    .seq_start_num(seq_start_num), .purge_start(purge_start),
    .standby_start(standby_start), .stop_all(stop_all), .seq_running(seq_running),
    .purge_active(purge_active), .standby_active(standby_active));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One request; req_valid stays up so calls run back to back
  task automatic acc(logic coil, logic wr, logic [7:0] a, logic d, logic e);
    req       = '{is_coil: coil, write: wr, addr: a, wdata: d};
    req_valid = 1'b1;
    rsp_q.push_back(e);
    @(negedge clk);
  endtask

  task automatic idle(int n);
    req_valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask

  function automatic logic di_exp(int a);
    case (a)
      8:       return pins.relay_fail;
      9:       return pins.lamp_gen_fail | pins.lamp_photo_fail;
      10:      return pins.panel_fail;
      11:      return pins.analog_cal_warn;
      12:      return pins.healthy;
      13:      return pins.gen_unstable;
      14:      return pins.cal_active;
      15:      return |exp_seq;
      16:      return pins.reg_press_warn & strap;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic coil_exp(int a);
    if (a < 100) return exp_seq[a];
    if (a == 100) return exp_purge;
    if (a == 101) return exp_stby;
    if (a >= 200 && a <= 211) return exp_ctrl[a-200];
    return 1'b0;
  endfunction

  // Code of the start pulse on show: sequence number, 100 purge, 101 standby
  function automatic logic [11:0] start_code();
    if (seq_start) return 12'(seq_start_num);
    if (purge_start) return 12'h064;
    return 12'h065;
  endfunction

  // Sweep every coil address, mapped and unmapped
  task automatic read_all();
    for (int a = 0; a < 256; a++) begin
      acc(1'b1, 1'b0, a[7:0], 1'b0, coil_exp(a));
    end
    idle(2);
  endtask

  // ************************************************************
  // Clock, monitor, watchdog
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Outputs settle after the rising edge; look at the falling edge
  always @(negedge clk) begin
    if (!rst) begin
      if (rsp_valid !== 1'b0) begin
        if (rsp_q.size() == 0) check("rsp_valid", 12'(rsp_valid), 12'h000);
        else check("rsp_data", 12'(rsp_data), 12'(rsp_q.pop_front()));
      end
      if ((seq_start | purge_start | standby_start) !== 1'b0) begin
        if (start_q.size() == 0) begin
          check("start", 12'({seq_start, purge_start, standby_start}), 12'h000);
        end else begin
          check("start_code", start_code(), 12'(start_q.pop_front()));
        end
      end
    end
  end

  initial begin
    #200000;
    errors++;
    test_done();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    logic [6:0]  n;
    logic [11:0] v;
    rst = 1'b1; req_valid = 1'b0; req = '0; pins = '0; strap = 1'b1; stop_all = 1'b0;
    exp_ctrl = '0; exp_seq = '0; exp_purge = 1'b0; exp_stby = 1'b0;
    errors = 0; comparisons = 0;
    void'($urandom(32'hc08d));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    idle(2);
    // Status map, with the pressure option fitted and then absent
    for (int ph = 0; ph < 2; ph++) begin
      for (int r = 0; r < 8; r++) begin
        pins = msb_status_t'($urandom);
        idle(6);
        for (int a = 0; a < 18; a++) begin
          acc(1'b0, 1'b0, a[7:0], 1'b0, di_exp(a));
        end
        acc(1'b0, 1'b1, 8'h0c, ~pins.healthy, 1'b0);
        acc(1'b0, 1'b0, 8'h0c, 1'b0, pins.healthy);
      end
      idle(2);
      rst = 1'b1;
      strap = 1'b0;
      idle(3);
      rst = 1'b0;
      idle(2);
    end
    check("ctrl_out_reset", ctrl_out, 12'h000);
    // Sequences: zero writes ignored, ones start, several at once
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 7'd0 : (i == 1) ? 7'd99 : 7'($urandom_range(98, 1));
      acc(1'b1, 1'b1, {1'b0, n}, 1'b0, 1'b0);
      start_q.push_back(n);
      acc(1'b1, 1'b1, {1'b0, n}, 1'b1, 1'b0);
      exp_seq[n] = 1'b1;
    end
    acc(1'b1, 1'b1, 8'h64, 1'b0, 1'b0);
    idle(3);
    read_all();
    acc(1'b0, 1'b0, 8'h0f, 1'b0, 1'b1);
    // Purge and standby alongside running sequences
    acc(1'b1, 1'b1, 8'h65, 1'b0, 1'b0);
    start_q.push_back(7'h64);
    acc(1'b1, 1'b1, 8'h64, 1'b1, 1'b0);
    start_q.push_back(7'h65);
    acc(1'b1, 1'b1, 8'h65, 1'b1, 1'b0);
    exp_purge = 1'b1;
    exp_stby = 1'b1;
    idle(3);
    acc(1'b1, 1'b1, 8'h64, 1'b0, 1'b0);
    read_all();
    // Activity ends; reads must fall back to zero
    stop_all = 1'b1;
    @(negedge clk);
    stop_all = 1'b0;
    exp_seq = '0; exp_purge = 1'b0; exp_stby = 1'b0;
    idle(2);
    read_all();
    // Control outputs set and cleared, then unmapped writes
    repeat (4) begin
      v = 12'($urandom);
      for (int i = 0; i < CTRL_N; i++) begin
        acc(1'b1, 1'b1, 8'(200 + i), v[i], 1'b0);
      end
      // Flip one output and read it straight back on the next cycle
      acc(1'b1, 1'b1, 8'hcd, ~v[5], 1'b0);
      acc(1'b1, 1'b0, 8'hcd, 1'b0, ~v[5]);
      v[5] = ~v[5];
      exp_ctrl = v;
      idle(2);
      check("ctrl_out", ctrl_out, exp_ctrl);
    end
    for (int i = 0; i < CTRL_N; i++) begin
      acc(1'b1, 1'b1, 8'($urandom_range(199, 102)), 1'b1, 1'b0);
      acc(1'b1, 1'b1, 8'($urandom_range(255, 212)), 1'b1, 1'b0);
    end
    idle(2);
    check("ctrl_out_unmapped", ctrl_out, exp_ctrl);
    read_all();
    idle(4);
    check("pending", 12'(rsp_q.size() + start_q.size()), 12'h000);
    test_done();
  end
endmodule
